/* rtl/pcb_pkg.sv */
// Shared constants and carriers for the profiling configuration and
// control-block pointer registers.
// Assumes a single core clock and a synchronous active-high reset.
package pcb_pkg;
    // Register addresses in the model-specific register space
    localparam logic [31:0] CB_PTR_ADDR = 32'hC0000106;
    // Configuration register address is a chosen default
    localparam logic [31:0] CFG_ADDR = 32'hC0000105;

    // Configuration field positions
    localparam int CFG_FREE_RUN_BIT = 29;
    localparam int CFG_TS_CAP_BIT = 30;
    localparam int CFG_THR_INT_BIT = 31;
    localparam int CFG_TAG_LSB = 32;
    localparam int CFG_VEC_LSB = 40;

    // Bits 47:29 are held; the rest read as zero
    localparam logic [63:0] CFG_WR_MASK = 64'h0000_FFFF_E000_0000;
    localparam logic [63:0] CFG_RESET = 64'h0;
    localparam logic [63:0] CB_PTR_RESET = 64'h0;
    localparam logic [63:0] ZERO64 = 64'h0;

    // Register access request from the instruction unit
    typedef struct packed {
        logic rd;
        logic wr;
        logic [31:0] addr;
        logic [63:0] wdata;
    } pcb_msr_req_t;

    // Fields that the block supplies to each stored event record
    typedef struct packed {
        logic [63:0] timestamp;
        logic [7:0] cpu_tag;
    } pcb_rec_fields_t;

    // Threshold interrupt request
    typedef struct packed {
        logic fire;
        logic [7:0] vector;
    } pcb_irq_t;
endpackage

/* rtl/pcb_regs.sv */
// Profiling configuration (upper fields) and control-block pointer
// registers, reached by register read and write instructions.
// Assumes every input comes from core logic on clk; no synchronisers.
`timescale 1ns/1ps
// Contract
// - Bit 29 allows free-running, else synchronized mode
// - Bit 30 stores timestamp counter in records
// - Threshold interrupt only with bit 31 set
// - Bits 39:32 copied to record cpu tag
// - Bits 47:40 give interrupt vector number
// - Pointer register exposes control block linear address
// - Pointer read returns address, no side effect
// - Nonzero pointer write raises protection fault
// - Zero write stops profiling, discards state
// - Block accesses use stored linear address directly
// - Pointer resets to zero, profiling disabled
module pcb_regs (
    input wire logic clk,
    input wire logic rst,
    input pcb_pkg::pcb_msr_req_t msr_req,
    output logic [63:0] msr_rdata,
    output logic msr_rd_valid,
    output logic msr_gp_fault,
    input wire logic extended_feature_mask_en,
    input wire logic cb_load_valid,
    input wire logic [63:0] cb_load_addr,
    input wire logic rec_req,
    input wire logic ts_counter_present,
    input wire logic [63:0] ts_counter,
    input wire logic threshold_exceeded,
    output logic profiling_active,
    output logic free_running_sampling_enable,
    output logic profiling_discard,
    output logic [63:0] cb_linear_addr,
    output logic rec_valid,
    output pcb_pkg::pcb_rec_fields_t rec_fields,
    output pcb_pkg::pcb_irq_t thr_irq
);
    logic [63:0] cfg_q;
    logic [63:0] cb_q;
    logic cfg_load;
    logic cb_load;
    logic [63:0] cb_din;
    logic hit_cfg;
    logic hit_cb;
    logic [63:0] rdata_d;
    logic [63:0] rdata_q;
    logic rd_valid_d;
    logic rd_valid_q;
    logic gp_d;
    logic gp_q;
    logic discard_d;
    logic discard_q;
    logic rec_valid_d;
    logic rec_valid_q;
    pcb_pkg::pcb_rec_fields_t rec_d;
    pcb_pkg::pcb_rec_fields_t rec_q;
    pcb_pkg::pcb_irq_t irq_d;
    pcb_pkg::pcb_irq_t irq_q;
    logic active;
    logic rd_req;
    logic wr_req;
    logic unmapped;
    logic ptr_zero_wr;
    logic ptr_bad_wr;
    logic cfg_free_run;
    logic cfg_ts_cap;
    logic cfg_thr_int;
    logic [7:0] cfg_tag;
    logic [7:0] cfg_vec;

    // Address decode
    always_comb begin
        hit_cfg = 1'b0;
        hit_cb = 1'b0;
        if (msr_req.addr == pcb_pkg::CFG_ADDR) begin
            hit_cfg = 1'b1;
        end else if (msr_req.addr == pcb_pkg::CB_PTR_ADDR) begin
            hit_cb = 1'b1;
        end
    end

    // Request qualification: a read wins when both strobes are high, so a
    // muddled request never changes state behind the answer it gets
    assign rd_req = msr_req.rd;
    assign wr_req = msr_req.wr && !msr_req.rd;
    assign unmapped = !(hit_cfg || hit_cb);
    assign ptr_zero_wr = wr_req && hit_cb
        && (msr_req.wdata == pcb_pkg::ZERO64);
    assign ptr_bad_wr = wr_req && hit_cb
        && (msr_req.wdata != pcb_pkg::ZERO64);

    // Write steering: software may only clear the pointer; nonzero
    // addresses arrive through the load path. A clear and a load in one
    // cycle resolve to the clear, so a stop request is never lost.
    always_comb begin
        cfg_load = wr_req && hit_cfg;
        cb_load = 1'b0;
        cb_din = cb_q;
        if (ptr_zero_wr) begin
            cb_load = 1'b1;
            cb_din = pcb_pkg::ZERO64;
        end else if (cb_load_valid) begin
            cb_load = 1'b1;
            cb_din = cb_load_addr;
        end
    end

    // Configuration upper fields; reserved bits never stored
    pcb_word_reg #(
        .W(64)
    ) u_cfg (
        .clk(clk),
        .rst(rst),
        .load(cfg_load),
        .din(msr_req.wdata & pcb_pkg::CFG_WR_MASK),
        .q(cfg_q)
    );

    // Control-block pointer, cleared by reset
    pcb_word_reg #(
        .W(64)
    ) u_cb (
        .clk(clk),
        .rst(rst),
        .load(cb_load),
        .din(cb_din),
        .q(cb_q)
    );

    // Profiling runs only with a loaded pointer and the feature enabled
    // Left combinational so a clear gates records in the very next cycle
    assign active = extended_feature_mask_en && (cb_q != pcb_pkg::ZERO64);

    // Register access answers, one cycle after the request
    always_comb begin
        rdata_d = rdata_q;
        rd_valid_d = 1'b0;
        gp_d = 1'b0;
        discard_d = 1'b0;
        if (rd_req) begin
            rd_valid_d = !unmapped;
            gp_d = unmapped;
            if (hit_cfg) begin
                rdata_d = cfg_q;
            end else if (hit_cb) begin
                rdata_d = cb_q;
            end
        end else if (wr_req) begin
            if (ptr_bad_wr) begin
                gp_d = 1'b1;
            end else if (ptr_zero_wr) begin
                discard_d = 1'b1;
            end else if (unmapped) begin
                gp_d = 1'b1;
            end
        end
    end

    // Named views of the held configuration fields
    assign cfg_free_run = cfg_q[pcb_pkg::CFG_FREE_RUN_BIT];
    assign cfg_ts_cap = cfg_q[pcb_pkg::CFG_TS_CAP_BIT];
    assign cfg_thr_int = cfg_q[pcb_pkg::CFG_THR_INT_BIT];
    assign cfg_tag = cfg_q[pcb_pkg::CFG_TAG_LSB +: 8];
    assign cfg_vec = cfg_q[pcb_pkg::CFG_VEC_LSB +: 8];

    // Record fields and threshold interrupt; the timestamp reads zero
    // when capture is off or no counter exists
    always_comb begin
        rec_valid_d = rec_req && active;
        rec_d = rec_q;
        if (rec_req && active) begin
            rec_d.cpu_tag = cfg_tag;
            if (cfg_ts_cap && ts_counter_present) begin
                rec_d.timestamp = ts_counter;
            end else begin
                rec_d.timestamp = pcb_pkg::ZERO64;
            end
        end
        irq_d.fire = threshold_exceeded && active
            && cfg_thr_int;
        // Vector follows the field every cycle, ready before any fire
        irq_d.vector = cfg_vec;
    end

    // Register access answer stage
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= pcb_pkg::ZERO64;
            rd_valid_q <= 1'b0;
            gp_q <= 1'b0;
            discard_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rd_valid_q <= rd_valid_d;
            gp_q <= gp_d;
            discard_q <= discard_d;
        end
    end

    // Record and interrupt stage
    always_ff @(posedge clk) begin
        if (rst) begin
            rec_valid_q <= 1'b0;
            rec_q <= '0;
            irq_q <= '0;
        end else begin
            rec_valid_q <= rec_valid_d;
            rec_q <= rec_d;
            irq_q <= irq_d;
        end
    end

    assign msr_rdata = rdata_q;
    assign msr_rd_valid = rd_valid_q;
    assign msr_gp_fault = gp_q;
    assign profiling_discard = discard_q;
    assign profiling_active = active;
    // Mode select reflects the stored bit directly
    assign free_running_sampling_enable = cfg_free_run;
    // Linear address used as is, with no segment base added
    assign cb_linear_addr = cb_q;
    assign rec_valid = rec_valid_q;
    assign rec_fields = rec_q;
    assign thr_irq = irq_q;
endmodule

/* rtl/pcb_word_reg.sv */
// Width-parameterised holding register with load enable.
// Assumes synchronous active-high reset; reset value is zero.
`timescale 1ns/1ps
module pcb_word_reg #(
    parameter int W = 64
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] din,
    output logic [W-1:0] q
);
    logic [W-1:0] q_d;
    logic [W-1:0] q_q;

    // Hold unless loaded
    always_comb begin
        q_d = load ? din : q_q;
    end

    // Register stage
    always_ff @(posedge clk) begin
        if (rst) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

    assign q = q_q;
endmodule

/* testbench/pcb_regs_monitor.sv */
// Port checker for the profiling register block.
// Assumes it is bound onto pcb_regs; one clock, synchronous reset.
`timescale 1ns/1ps
module pcb_regs_monitor (
    input wire logic clk,
    input wire logic rst,
    input pcb_pkg::pcb_msr_req_t msr_req,
    input wire logic [63:0] msr_rdata,
    input wire logic msr_rd_valid,
    input wire logic msr_gp_fault,
    input wire logic cb_load_valid,
    input wire logic [63:0] cb_load_addr,
    input wire logic rec_req,
    input wire logic threshold_exceeded,
    input wire logic profiling_active,
    input wire logic free_running_sampling_enable,
    input wire logic profiling_discard,
    input wire logic [63:0] cb_linear_addr,
    input wire logic rec_valid,
    input pcb_pkg::pcb_irq_t thr_irq
);
    logic wr_ok;
    logic pw;
    // Write not overridden by a read; pointer write decoded here
    assign wr_ok = msr_req.wr && !msr_req.rd;
    assign pw = wr_ok && msr_req.addr == pcb_pkg::CB_PTR_ADDR;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_ptr_read_ans: assert property (
        msr_req.rd && msr_req.addr == pcb_pkg::CB_PTR_ADDR |=> msr_rd_valid
        && msr_rdata == $past(cb_linear_addr)) else $error("pointer read");
    a_nonzero_fault: assert property (
        pw && msr_req.wdata != pcb_pkg::ZERO64 && !cb_load_valid
        |=> msr_gp_fault && $stable(cb_linear_addr))
        else $error("nonzero write kept");
    a_zero_wr_stop: assert property (
        pw && msr_req.wdata == pcb_pkg::ZERO64 |=> profiling_discard
        && !profiling_active && cb_linear_addr == pcb_pkg::ZERO64)
        else $error("zero write no stop");
    a_free_run_bit: assert property (
        wr_ok && msr_req.addr == pcb_pkg::CFG_ADDR
        |=> free_running_sampling_enable
        == $past(msr_req.wdata[pcb_pkg::CFG_FREE_RUN_BIT]))
        else $error("free run bit");
    a_rec_gate: assert property (
        rec_valid == $past(rec_req && profiling_active)) else $error("record");
    a_irq_gate: assert property (
        thr_irq.fire |-> $past(threshold_exceeded && profiling_active))
        else $error("stray irq");
    a_reset_clear: assert property (
        $fell(rst) |-> cb_linear_addr == pcb_pkg::ZERO64 && !profiling_active)
        else $error("pointer not clear");
    a_load_ptr: assert property (
        cb_load_valid && !pw |=> cb_linear_addr == $past(cb_load_addr))
        else $error("load lost");
    c_rec: cover property (rec_valid);
    c_irq: cover property (thr_irq.fire);
    c_discard: cover property (profiling_discard);
endmodule
bind pcb_regs pcb_regs_monitor mon (.*);

/* testbench/tb_top.sv */
// Self-checking bench for the profiling register block.
// Assumes pcb_regs and its monitor are compiled before it.
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rst = 1, rec_req = 0, threshold_exceeded = 0;
    logic extended_feature_mask_en = 1, cb_load_valid = 0;
    logic ts_counter_present = 0, msr_rd_valid, msr_gp_fault;
    logic profiling_active, profiling_discard, rec_valid;
    logic free_running_sampling_enable;
    logic [63:0] cb_load_addr = '0, ts_counter = '0;
    logic [63:0] msr_rdata, cb_linear_addr, cfg, a;
    pcb_pkg::pcb_msr_req_t msr_req = '0;
    pcb_pkg::pcb_rec_fields_t rec_fields;
    pcb_pkg::pcb_irq_t thr_irq;
    int err_total = 0, checks_done = 0, seed = 32'hA6D1;
    pcb_regs dut (.*);
    initial begin
        forever #10 clk = ~clk;
    end
    // Timestamp only when enabled and a counter exists
    function automatic logic [63:0] ts_exp(logic [63:0] c);
        return (c[30] && ts_counter_present) ? ts_counter : 64'h0;
    endfunction
    task automatic chk(string n, logic [63:0] got, logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, exp, got);
        end
    endtask
    // One request held for one taking edge; answer seen on return
    task automatic msr(logic r, logic w, logic [31:0] ad, logic [63:0] d);
        @(posedge clk) #1;
        msr_req = '{r, w, ad, d};
        @(posedge clk) #1;
        msr_req = '0;
    endtask
    task automatic pulse(logic r, logic t, logic l);
        @(posedge clk) #1;
        rec_req = r;
        threshold_exceeded = t;
        cb_load_valid = l;
        @(posedge clk) #1;
        {rec_req, threshold_exceeded, cb_load_valid} = 3'h0;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog: the tests need well under a thousand cycles
    initial begin
        #20000;
        err_total++;
        results();
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 0;
        chk("ptr", cb_linear_addr, 64'h0);
        chk("act", profiling_active, 64'h0);
        repeat (6) begin
            cfg = {$random(seed), $random(seed)};
            ts_counter = {$random(seed), $random(seed)};
            ts_counter_present = cfg[0];
            a = {$random(seed), 32'h40};
            cb_load_addr = a;
            msr(0, 1, pcb_pkg::CFG_ADDR, cfg);
            chk("run", free_running_sampling_enable, cfg[29]);
            msr(1, 0, pcb_pkg::CFG_ADDR, 64'h0);
            chk("cfg", msr_rdata, cfg & pcb_pkg::CFG_WR_MASK);
            pulse(0, 0, 1);
            chk("load", cb_linear_addr, a);
            msr(1, 0, pcb_pkg::CB_PTR_ADDR, 64'h0);
            chk("rd", msr_rdata, a);
            chk("rdv", msr_rd_valid, 64'h1);
            chk("lin", cb_linear_addr, a);
            msr(0, 1, pcb_pkg::CB_PTR_ADDR, a);
            chk("gp", msr_gp_fault, 64'h1);
            chk("kept", cb_linear_addr, a);
            pulse(1, 1, 0);
            chk("rec", rec_valid, 64'h1);
            chk("ts", rec_fields.timestamp, ts_exp(cfg));
            chk("tag", rec_fields.cpu_tag, cfg[39:32]);
            chk("irq", thr_irq.fire, cfg[31]);
            chk("vec", thr_irq.vector, cfg[47:40]);
            msr(0, 1, pcb_pkg::CB_PTR_ADDR, 64'h0);
            chk("disc", profiling_discard, 64'h1);
            chk("stop", cb_linear_addr, 64'h0);
            pulse(1, 1, 0);
            chk("idle", rec_valid | thr_irq.fire, 64'h0);
            $display("pass of register test done");
        end
        // Corner: read and write together, the read wins
        msr(0, 1, pcb_pkg::CFG_ADDR, 64'hFFFF_FFFF_FFFF_FFFF);
        msr(1, 1, pcb_pkg::CFG_ADDR, 64'h0);
        chk("both", msr_rdata, pcb_pkg::CFG_WR_MASK);
        chk("bothv", msr_rd_valid, 64'h1);
        chk("held", free_running_sampling_enable, 64'h1);
        // Corner: a clear in the same cycle as a load wins
        pulse(0, 0, 1);
        chk("ld", cb_linear_addr, a);
        @(posedge clk) #1;
        cb_load_valid = 1;
        msr_req = '{1'b0, 1'b1, pcb_pkg::CB_PTR_ADDR, 64'h0};
        @(posedge clk) #1;
        cb_load_valid = 0;
        msr_req = '0;
        chk("zwin", cb_linear_addr, 64'h0);
        chk("zdisc", profiling_discard, 64'h1);
        // Corner: feature withdrawn, records and interrupts ignored
        pulse(0, 0, 1);
        extended_feature_mask_en = 0;
        #1 chk("off", profiling_active, 64'h0);
        pulse(1, 1, 0);
        chk("offr", rec_valid | thr_irq.fire, 64'h0);
        extended_feature_mask_en = 1;
        $display("corner tests done");
        // Mid-run reset with a loaded pointer and a set configuration
        @(posedge clk) #1;
        rst = 1;
        repeat (3) @(posedge clk);
        #1 rst = 0;
        chk("rptr", cb_linear_addr, 64'h0);
        chk("ract", profiling_active, 64'h0);
        chk("rrun", free_running_sampling_enable, 64'h0);
        $display("reset test done");
        msr(1, 0, 32'hC0000107, 64'h0);
        chk("unmap", {msr_gp_fault, msr_rd_valid}, 64'h2);
        $display("unmapped test done");
        results();
    end
endmodule
